// >>> core/dtu_pkg.sv
package dtu_pkg;
  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] DUR_OFFSET = 8'h00;
  localparam logic [7:0] SEL_OFFSET = 8'h04;
  localparam logic [7:0] STAT_OFFSET = 8'h08;
  // ----------------------------------------------------------------
  // reset values and field positions
  // ----------------------------------------------------------------
  localparam logic [15:0] DUR_RESET = 16'h0000;
  localparam logic [7:0] SEL_RESET = 8'h00;
  localparam int A_COUNT_LSB = 0;
  localparam int A_PRESCALE_LSB = 6;
  localparam int B_COUNT_LSB = 8;
  localparam int B_PRESCALE_LSB = 14;
  localparam int COUNT_W = 6;
  localparam int NUM_GEN = 4;
  // ----------------------------------------------------------------
  // prescale codes and their cycle counts
  // ----------------------------------------------------------------
  localparam logic [1:0] PRE_DIV1 = 2'h0;
  localparam logic [1:0] PRE_DIV2 = 2'h1;
  localparam logic [1:0] PRE_DIV4 = 2'h2;
  localparam logic [1:0] PRE_DIV8 = 2'h3;
  localparam logic [3:0] TICKS_DIV1 = 4'h1;
  localparam logic [3:0] TICKS_DIV2 = 4'h2;
  localparam logic [3:0] TICKS_DIV4 = 4'h4;
  localparam logic [3:0] TICKS_DIV8 = 4'h8;
  // ----------------------------------------------------------------
  // per-output dead time states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    DTU_OFF   = 3'b001,
    DTU_DEAD  = 3'b010,
    DTU_ON    = 3'b100
  } dtu_state_t;
endpackage

// >>> core/dtu_dead_time_unit_select.sv
`timescale 1ns/1ns
// Functional notes
// - Bits 15 to 8 of the unit select register do not exist, read as zero and ignore writes.
// - Each generator's inactive-edge select bit picks unit B when 1 and unit A when 0; generator four's is bit 6.
// - Each generator's active-edge select bit picks unit B when 1 and unit A when 0; generator three's is bit 5.
// - The low byte holds eight read-write select bits reset to zero, bit 7 gen4 active down to bit 0 gen1 inactive.
// - Unit A dead time is its six-bit count times its selected clock period.
// - A two-bit prescale of 00, 01, 10, 11 gives a period of 1, 2, 4 or 8 instruction cycles.
// - Unit B dead time is formed the same way from its own count and prescale.
module dtu_dead_time_unit_select (
  input wire logic ref_clk_i, // instruction clock
  input wire logic arst_n_i, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire logic [3:0] duty_i, // raw duty level per generator
  output logic [3:0] pwm_high_o, // high side drive per generator
  output logic [3:0] pwm_low_o // low side drive per generator
);
  // ----------------------------------------------------------------
  // register bus
  // ----------------------------------------------------------------
  logic [15:0] dead_time_duration_control_q;
  logic [7:0] dead_time_unit_select_q;
  logic [3:0] dead_q;
  logic acc, hit_dur, hit_sel, hit_stat;
  assign acc = psel && penable && pready;
  assign hit_dur = paddr == dtu_pkg::DUR_OFFSET;
  assign hit_sel = paddr == dtu_pkg::SEL_OFFSET;
  assign hit_stat = paddr == dtu_pkg::STAT_OFFSET;

  // one wait state: pready rises in the second access cycle
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pready <= 1'b0;
    end else begin
      pready <= psel && penable && !pready;
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      dead_time_duration_control_q <= dtu_pkg::DUR_RESET;
    end else if (acc && pwrite && hit_dur) begin
      dead_time_duration_control_q <= pwdata[15:0];
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      dead_time_unit_select_q <= dtu_pkg::SEL_RESET;
    end else if (acc && pwrite && hit_sel) begin
      dead_time_unit_select_q <= pwdata[7:0];
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
      if (psel && penable && !pready) begin
        if (hit_dur) begin
          prdata <= {16'h0000, dead_time_duration_control_q};
        end else if (hit_sel) begin
          prdata <= {24'h00_0000, dead_time_unit_select_q};
        end else if (hit_stat) begin
          prdata <= {28'h000_0000, dead_q};
        end else begin
          pslverr <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // register bus checks
  // ----------------------------------------------------------------
  sel_upper_zero_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    pready && !pwrite && hit_sel |-> prdata[31:8] == 24'h00_0000)
    else $error("select upper bits not zero");

  sel_write_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    acc && pwrite && hit_sel |=> dead_time_unit_select_q == $past(pwdata[7:0]))
    else $error("select write did not land");

  dur_write_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    acc && pwrite && hit_dur |=> dead_time_duration_control_q == $past(pwdata[15:0]))
    else $error("duration write did not land");

  bad_addr_err_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    pready && !(hit_dur || hit_sel || hit_stat) |-> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped access not refused");

  good_addr_ok_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    pready && (hit_dur || hit_sel || hit_stat) |-> !pslverr)
    else $error("mapped access flagged as error");

  stat_read_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    pready && !pwrite && hit_stat |-> prdata[31:4] == 28'h000_0000)
    else $error("status upper bits not zero");

  // ----------------------------------------------------------------
  // dead time lengths of units a and b
  // ----------------------------------------------------------------
  function automatic logic [9:0] dead_len(input logic [5:0] cnt, input logic [1:0] pre);
    logic [3:0] tk;
    tk = dtu_pkg::TICKS_DIV1;
    unique case (pre)
      dtu_pkg::PRE_DIV1: tk = dtu_pkg::TICKS_DIV1;
      dtu_pkg::PRE_DIV2: tk = dtu_pkg::TICKS_DIV2;
      dtu_pkg::PRE_DIV4: tk = dtu_pkg::TICKS_DIV4;
      dtu_pkg::PRE_DIV8: tk = dtu_pkg::TICKS_DIV8;
    endcase
    return 10'(cnt) * 10'(tk);
  endfunction

  logic [9:0] len_a, len_b;
  assign len_a = dead_len(dead_time_duration_control_q[dtu_pkg::A_COUNT_LSB +: dtu_pkg::COUNT_W],
    dead_time_duration_control_q[dtu_pkg::A_PRESCALE_LSB +: 2]);
  assign len_b = dead_len(dead_time_duration_control_q[dtu_pkg::B_COUNT_LSB +: dtu_pkg::COUNT_W],
    dead_time_duration_control_q[dtu_pkg::B_PRESCALE_LSB +: 2]);

  // length is count shifted by the prescale code
  a_length_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    len_a == ({4'h0, dead_time_duration_control_q[dtu_pkg::A_COUNT_LSB +: dtu_pkg::COUNT_W]}
      << dead_time_duration_control_q[dtu_pkg::A_PRESCALE_LSB +: 2]))
    else $error("unit a length wrong");

  b_length_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    len_b == ({4'h0, dead_time_duration_control_q[dtu_pkg::B_COUNT_LSB +: dtu_pkg::COUNT_W]}
      << dead_time_duration_control_q[dtu_pkg::B_PRESCALE_LSB +: 2]))
    else $error("unit b length wrong");

  // ----------------------------------------------------------------
  // complementary outputs with dead time insertion
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < dtu_pkg::NUM_GEN; g++) begin : gen_pair
      logic act_sel, inact_sel;
      logic [9:0] len_on, len_off, cnt_q;
      logic duty_q;
      dtu_pkg::dtu_state_t st_q;
      assign act_sel = dead_time_unit_select_q[2 * g + 1];
      assign inact_sel = dead_time_unit_select_q[2 * g];
      assign len_on = act_sel ? len_b : len_a;
      assign len_off = inact_sel ? len_b : len_a;

      always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
          duty_q <= 1'b0;
          cnt_q <= 10'h000;
          pwm_high_o[g] <= 1'b0;
          pwm_low_o[g] <= 1'b0;
          dead_q[g] <= 1'b0;
          st_q <= dtu_pkg::DTU_OFF;
        end else begin
          duty_q <= duty_i[g];
          unique case (st_q)
            dtu_pkg::DTU_OFF, dtu_pkg::DTU_ON: begin
              if (duty_i[g] != duty_q) begin
                // both off, then count the edge's dead time
                pwm_high_o[g] <= 1'b0;
                pwm_low_o[g] <= 1'b0;
                dead_q[g] <= 1'b1;
                cnt_q <= duty_i[g] ? len_on : len_off;
                st_q <= dtu_pkg::DTU_DEAD;
              end else begin
                pwm_high_o[g] <= duty_q;
                pwm_low_o[g] <= !duty_q;
              end
            end
            dtu_pkg::DTU_DEAD: begin
              if (duty_i[g] != duty_q) begin
                cnt_q <= duty_i[g] ? len_on : len_off;
              end else if (cnt_q <= 10'h001) begin
                pwm_high_o[g] <= duty_q;
                pwm_low_o[g] <= !duty_q;
                dead_q[g] <= 1'b0;
                st_q <= duty_q ? dtu_pkg::DTU_ON : dtu_pkg::DTU_OFF;
              end else begin
                cnt_q <= cnt_q - 10'h001;
              end
            end
            default: begin
              st_q <= dtu_pkg::DTU_OFF;
            end
          endcase
        end
      end

      // ----------------------------------------------------------------
      // pair checks
      // ----------------------------------------------------------------
      no_shoot_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        !(pwm_high_o[g] && pwm_low_o[g]))
        else $error("both switches of a pair on");

      high_gap_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        $rose(pwm_high_o[g]) |-> $past(!pwm_low_o[g], 1) && $past(dead_q[g], 1))
        else $error("high side on without a gap");

      low_gap_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        $rose(pwm_low_o[g]) |-> $past(!pwm_high_o[g], 1))
        else $error("low side on without a gap");

      dead_off_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        dead_q[g] |-> !pwm_high_o[g] && !pwm_low_o[g])
        else $error("pair driven during dead time");

      on_unit_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        $rose(dead_q[g]) && duty_q |->
          cnt_q == ($past(dead_time_unit_select_q[2 * g + 1]) ? $past(len_b) : $past(len_a)))
        else $error("active edge used the wrong unit");

      off_unit_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        $rose(dead_q[g]) && !duty_q |->
          cnt_q == ($past(dead_time_unit_select_q[2 * g]) ? $past(len_b) : $past(len_a)))
        else $error("inactive edge used the wrong unit");
    end
  endgenerate
endmodule

// >>> bench/dtu_gate_model.sv
`timescale 1ns/1ns
module dtu_gate_model (
  input wire logic ref_clk_i, // instruction clock
  input wire logic arst_n_i, // async reset, active low
  input wire logic [3:0] high_i, // high side gates
  input wire logic [3:0] low_i, // low side gates
  output logic shoot_o // sticky: both switches of a pair conducting
);
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      shoot_o <= 1'b0;
    end else if (|(high_i & low_i)) begin
      shoot_o <= 1'b1;
    end
  end
endmodule

// >>> bench/dtu_dead_time_unit_select_bench.sv
`timescale 1ns/1ns
module dtu_dead_time_unit_select_bench;
  logic ref_clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic shoot;
  logic [3:0] duty_i = 4'h0;
  logic [3:0] pwm_high_o;
  logic [3:0] pwm_low_o;
  logic [31:0] rd;
  logic er;
  int err_count = 0;
  int checked = 0;
  typedef struct {logic [15:0] dur; logic [7:0] sel; int ta; int tb;} dtu_row_t;
  // duration word, select byte, unit a and unit b dead cycles
  dtu_row_t rows [5] = '{'{16'h03c5, 8'h55, 40, 3}, '{16'h4385, 8'haa, 20, 6},
    '{16'h8345, 8'h55, 10, 12}, '{16'hc305, 8'haa, 5, 24}, '{16'h00ff, 8'h0f, 504, 1}};
  always #25 ref_clk_i = ~ref_clk_i;
  dtu_dead_time_unit_select dut (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .duty_i(duty_i), .pwm_high_o(pwm_high_o), .pwm_low_o(pwm_low_o));
  dtu_gate_model gate (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .high_i(pwm_high_o),
    .low_i(pwm_low_o), .shoot_o(shoot));
  task close_out;
    if (err_count == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task chk(input string n, input logic [31:0] ex, input logic [31:0] s);
    checked++;
    if (s !== ex) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", n, ex, s);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk_i);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk_i);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task edge_time(input int g, input logic up, input int ex);
    int n;
    @(posedge ref_clk_i);
    duty_i[g] <= up;
    n = 0;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while ((up ? pwm_high_o[g] : pwm_low_o[g]) !== 1'b1 && n < 600);
    chk("dead cycles", ex + 2, n);
  endtask
  initial begin
    #2000000;
    err_count++;
    close_out;
  end
  initial begin
    repeat (2) @(posedge ref_clk_i);
    arst_n_i <= 1'b1;
    apb(1'b0, dtu_pkg::SEL_OFFSET, 32'h0);
    chk("select reset", 32'h0, rd);
    apb(1'b1, 8'h3c, 32'hffffffff);
    chk("unmapped error", 32'h1, {31'h0, er});
    apb(1'b0, 8'h3c, 32'h0);
    chk("unmapped read", 32'h0, rd);
    apb(1'b0, dtu_pkg::DUR_OFFSET, 32'h0);
    chk("unmapped write ignored", 32'h0, rd);
    foreach (rows[i]) begin
      apb(1'b1, dtu_pkg::DUR_OFFSET, {16'h0, rows[i].dur});
      apb(1'b0, dtu_pkg::DUR_OFFSET, 32'h0);
      chk("duration readback", {16'h0, rows[i].dur}, rd);
      apb(1'b1, dtu_pkg::SEL_OFFSET, {24'hffffff, rows[i].sel});
      apb(1'b0, dtu_pkg::SEL_OFFSET, 32'h0);
      chk("select readback", {24'h0, rows[i].sel}, rd);
      chk("mapped error", 32'h0, {31'h0, er});
      for (int g = 0; g < 4; g++) begin
        edge_time(g, 1'b1, rows[i].sel[2*g+1] ? rows[i].tb : rows[i].ta);
        edge_time(g, 1'b0, rows[i].sel[2*g] ? rows[i].tb : rows[i].ta);
      end
    end
    apb(1'b1, dtu_pkg::SEL_OFFSET, 32'h0000_00fc);
    duty_i[0] <= 1'b1;
    apb(1'b0, dtu_pkg::STAT_OFFSET, 32'h0);
    chk("dead status", 32'h1, rd);
    edge_time(0, 1'b0, 504);
    apb(1'b0, dtu_pkg::STAT_OFFSET, 32'h0);
    chk("idle status", 32'h0, rd);
    chk("shoot through", 32'h0, {31'h0, shoot});
    arst_n_i <= 1'b0;
    @(posedge ref_clk_i);
    arst_n_i <= 1'b1;
    apb(1'b0, dtu_pkg::SEL_OFFSET, 32'h0);
    chk("select after reset", 32'h0, rd);
    apb(1'b0, dtu_pkg::DUR_OFFSET, 32'h0);
    chk("duration after reset", 32'h0, rd);
    chk("low side after reset", 32'hf, {28'h0, pwm_low_o});
    chk("high side after reset", 32'h0, {28'h0, pwm_high_o});
    close_out;
  end
endmodule
